// ---- include/amp_ctrl_pkg.sv ----
// Purpose: shared constants and types of the amplifier control block
// Assumes: system clock of 40 MHz, serial control link clocked by scl
// Notes:   control bytes reset to zero, which means muted, standby, full gain
package amp_ctrl_pkg;
  // ------------------------------------------------------------
  // link addressing
  // ------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR      = 7'h6c;  // full byte d8h, direction bit clear
  localparam logic [6:0] SUB_CTRL1       = 7'h01;
  localparam logic [6:0] SUB_CTRL2       = 7'h02;
  localparam int         SUB_AUTOINC_BIT = 7;
  localparam logic [3:0] BIT_LAST        = 4'h7;   // last data bit of a byte
  localparam logic [3:0] BIT_ACK         = 4'h8;   // acknowledge clock
  // ------------------------------------------------------------
  // control byte fields
  // ------------------------------------------------------------
  localparam int         C1_CLIP_TEN     = 0;      // 1: clip threshold 10 %
  localparam int         C1_REAR_PLAY    = 1;
  localparam int         C1_FRONT_PLAY   = 2;
  localparam int         C1_REAR_LOW     = 3;      // 1: rear gain 12 db
  localparam int         C1_FRONT_LOW    = 4;      // 1: front gain 12 db
  localparam int         C2_STANDBY_OFF  = 4;
  localparam int         C2_FAST_MUTE    = 6;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [6:0] SYNC_RESET      = 7'h6c;  // pins idle high, toggle low, force levels high
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned MUTE_DELAY_MS     = 30;  // least charge delay
  localparam int unsigned MUTE_DELAY_CYCLES = (MUTE_DELAY_MS * CLK_HZ + 999) / 1000;
  localparam int          CNT_W             = 21;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [6:0] sub;
    logic [7:0] data;
  } ctrl_write_s;
  typedef enum logic [1:0] {ph_addr, ph_sub, ph_data, ph_idle} link_phase_e;
  typedef enum logic [1:0] {st_muted, st_play, st_muting} mute_state_e;
endpackage : amp_ctrl_pkg

// ---- src/amp_i2c_link.sv ----
// Purpose: serial slave on the scl clock, turns write bytes into control words
// Assumes: link_hold is raised between frames and drops while scl is high
// Notes:   read frames are acknowledged, data bits are left released
`timescale 1ns/1ps
module amp_i2c_link
  import amp_ctrl_pkg::*;
(
  // link clock and frame hold
  input  wire logic        scl,
  input  wire logic        link_hold,
  // data pin
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  // control word to the system domain
  output ctrl_write_s      wr,
  output logic             wr_toggle
);
  logic [3:0]  cnt, next_cnt;
  logic [6:0]  shreg, next_shreg;
  link_phase_e phase, next_phase;
  logic [6:0]  sub, next_sub;
  logic        autoinc, next_autoinc;
  logic        ack, next_ack;
  ctrl_write_s next_wr;
  logic        next_wr_toggle;
  logic [7:0]  byte_in;

  assign sda_o   = 1'b0;  // open drain, only pulls low
  assign byte_in = {shreg, sda_i};

  // ------------------------------------------------------------
  // byte framing and decode
  // ------------------------------------------------------------
  always_comb begin
    next_cnt       = cnt;
    next_shreg     = shreg;
    next_phase     = phase;
    next_sub       = sub;
    next_autoinc   = autoinc;
    next_ack       = 1'b0;
    next_wr        = wr;
    next_wr_toggle = wr_toggle;
    if (cnt == BIT_ACK) begin
      next_cnt = 4'h0;
    end else begin
      next_cnt   = cnt + 4'h1;
      next_shreg = byte_in[6:0];
      if (cnt == BIT_LAST) begin
        case (phase)
          ph_addr: begin
            next_ack   = (byte_in[7:1] == SLAVE_ADDR);
            next_phase = (next_ack && !byte_in[0]) ? ph_sub : ph_idle;
          end
          ph_sub: begin
            next_ack     = 1'b1;
            next_sub     = byte_in[6:0];
            next_autoinc = byte_in[SUB_AUTOINC_BIT];
            next_phase   = ph_data;
          end
          ph_data: begin
            next_ack       = 1'b1;
            next_wr        = '{sub: sub, data: byte_in};
            next_wr_toggle = ~wr_toggle;
            if (autoinc) begin
              next_sub = sub + 7'h01;
            end
          end
          default: begin
            next_ack = 1'b0;
          end
        endcase
      end
    end
  end

  // registers on the rising scl edge
  always_ff @(posedge scl or posedge link_hold) begin
    if (link_hold) begin
      cnt       <= 4'h0;
      shreg     <= 7'h00;
      phase     <= ph_addr;
      sub       <= 7'h00;
      autoinc   <= 1'b0;
      ack       <= 1'b0;
      wr        <= '0;
      wr_toggle <= 1'b0;
    end else begin
      cnt       <= next_cnt;
      shreg     <= next_shreg;
      phase     <= next_phase;
      sub       <= next_sub;
      autoinc   <= next_autoinc;
      ack       <= next_ack;
      wr        <= next_wr;
      wr_toggle <= next_wr_toggle;
    end
  end

  // acknowledge drive, changed while scl is low
  always_ff @(negedge scl or posedge link_hold) begin
    if (link_hold) begin
      sda_oe_n <= 1'b1;
    end else begin
      sda_oe_n <= !(ack && (cnt == BIT_ACK));
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_addr_nack: assert property (@(posedge scl) disable iff (link_hold)
    (cnt == BIT_LAST && phase == ph_addr && byte_in[7:1] != SLAVE_ADDR) |=> !ack && phase == ph_idle)
    else $error("foreign address acknowledged");
  a_sub_inc: assert property (@(posedge scl) disable iff (link_hold)
    (cnt == BIT_LAST && phase == ph_data && autoinc) |=> sub == 7'($past(sub) + 7'h01) && wr.sub == $past(sub))
    else $error("sub address did not step");
  a_sub_fixed: assert property (@(posedge scl) disable iff (link_hold)
    (cnt == BIT_LAST && phase == ph_data && !autoinc) |=> sub == $past(sub) && wr_toggle != $past(wr_toggle))
    else $error("sub address moved without auto increment");
endmodule : amp_i2c_link

// ---- src/amp_i2c_mute_gain_control.sv ----
// Purpose: gain, mute sequencing and clip flag of a four channel amplifier
// Assumes: scl and sda come from pins; analog detectors arrive as async levels
// Notes:   link logic runs on scl, control words cross by toggle
`timescale 1ns/1ps

// Functional notes
// - reduced gain bit lowers total gain from 26 db to 12 db.
// - mute-on takes effect only after the charge delay of 30 to 180 ms.
// - fast supply drop mutes the amplifier without any link command.
// - device starts muted; host must send mute-off before audio plays.
// - clip output transistor is on only while the output clips.
// - host selects clip threshold of 1 % or 10 % distortion.
// - fast mute bit discharges the timing capacitor and mutes at once.
// - sub address bit 7 low writes only the addressed control byte.
// - sub address bit 7 high steps from byte 01h to 02h.
// - internal self mute engages near 7.8 v supply.
module amp_i2c_mute_gain_control
  import amp_ctrl_pkg::*;
#(
  parameter int unsigned MUTE_CYCLES = MUTE_DELAY_CYCLES
)(
  // system clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // serial control link
  input  wire logic scl,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_n,
  // analog status levels
  input  wire logic supply_low,
  input  wire logic timing_pin_low,
  input  wire logic clip_1pct,
  input  wire logic clip_10pct,
  // amplifier controls
  output logic      gain_low_front,
  output logic      gain_low_rear,
  output logic      audio_mute,
  output logic      standby,
  output logic      timing_discharge,
  // clip flag, open collector
  output logic      clip_o,
  output logic      clip_oe_n
);
  // ------------------------------------------------------------
  // link and input synchronisers
  // ------------------------------------------------------------
  ctrl_write_s wr;
  logic        wr_toggle;
  logic        link_hold, next_link_hold;
  logic        hold_pend, next_hold_pend;
  logic [6:0]  sync_m, sync_s, sync_d;
  logic        scl_s, sda_s, tog_s, supply_s, pin_s, c1_s, c10_s;
  logic        start_seen, stop_seen, wr_evt;

  amp_i2c_link u_link (
    .scl       (scl),
    .link_hold (link_hold),
    .sda_i     (sda_i),
    .sda_o     (sda_o),
    .sda_oe_n  (sda_oe_n),
    .wr        (wr),
    .wr_toggle (wr_toggle)
  );

  // two stages plus one for edge detection
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sync_m <= SYNC_RESET;  // toggle tap matches the link idle, no false write
      sync_s <= SYNC_RESET;
      sync_d <= SYNC_RESET;
    end else begin
      sync_m <= {scl, sda_i, wr_toggle, supply_low, timing_pin_low, clip_1pct, clip_10pct};
      sync_s <= sync_m;
      sync_d <= sync_s;
    end
  end

  // named taps of the second stage
  assign {scl_s, sda_s, tog_s, supply_s, pin_s, c1_s, c10_s} = sync_s;
  assign start_seen = scl_s && sync_d[6] && sync_d[5] && !sda_s;
  assign stop_seen  = scl_s && sync_d[6] && !sync_d[5] && sda_s;
  assign wr_evt     = tog_s != sync_d[4];

  // ------------------------------------------------------------
  // frame hold: keeps the link cleared between frames
  // ------------------------------------------------------------
  always_comb begin
    next_link_hold = link_hold;
    next_hold_pend = 1'b0;
    if (stop_seen) begin
      next_link_hold = 1'b1;
    end else if (start_seen) begin
      next_link_hold = 1'b1;
      next_hold_pend = 1'b1;
    end else if (hold_pend) begin
      next_link_hold = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      link_hold <= 1'b1;
      hold_pend <= 1'b0;
    end else begin
      link_hold <= next_link_hold;
      hold_pend <= next_hold_pend;
    end
  end

  // ------------------------------------------------------------
  // control bytes
  // ------------------------------------------------------------
  logic [7:0] ctrl1, next_ctrl1;
  logic [7:0] ctrl2, next_ctrl2;

  always_comb begin
    next_ctrl1 = ctrl1;
    next_ctrl2 = ctrl2;
    if (wr_evt) begin
      case (wr.sub)
        SUB_CTRL1: next_ctrl1 = wr.data;
        SUB_CTRL2: next_ctrl2 = wr.data;
        default:   next_ctrl1 = ctrl1;  // other sub addresses ignored
      endcase
    end
    if (!next_ctrl2[C2_STANDBY_OFF]) begin
      next_ctrl1[C1_FRONT_PLAY] = 1'b0;
      next_ctrl1[C1_REAR_PLAY]  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl1 <= CTRL_RESET;
      ctrl2 <= CTRL_RESET;
    end else begin
      ctrl1 <= next_ctrl1;
      ctrl2 <= next_ctrl2;
    end
  end

  // ------------------------------------------------------------
  // mute sequencing
  // ------------------------------------------------------------
  mute_state_e      state, next_state;
  logic [CNT_W-1:0] mute_cnt, next_mute_cnt;
  logic             force_mute, play_req;

  assign force_mute = supply_s || pin_s || ctrl2[C2_FAST_MUTE] || !ctrl2[C2_STANDBY_OFF];
  assign play_req   = ctrl1[C1_FRONT_PLAY] || ctrl1[C1_REAR_PLAY];

  always_comb begin
    next_state    = state;
    next_mute_cnt = mute_cnt;
    case (state)
      st_muted: begin
        next_mute_cnt = '0;
        if (!force_mute && play_req) begin
          next_state = st_play;
        end
      end
      st_play: begin
        if (force_mute) begin
          next_state = st_muted;
        end else if (!play_req) begin
          next_state    = st_muting;
          next_mute_cnt = '0;
        end
      end
      st_muting: begin
        if (force_mute || mute_cnt == CNT_W'(MUTE_CYCLES - 1)) begin
          next_state = st_muted;
        end else begin
          next_mute_cnt = mute_cnt + 1'b1;
        end
      end
      default: begin
        next_state = st_muted;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state    <= st_muted;
      mute_cnt <= '0;
    end else begin
      state    <= next_state;
      mute_cnt <= next_mute_cnt;
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  assign clip_o = 1'b0;  // transistor only pulls low

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      gain_low_front   <= 1'b0;
      gain_low_rear    <= 1'b0;
      audio_mute       <= 1'b1;
      standby          <= 1'b1;
      timing_discharge <= 1'b0;
      clip_oe_n        <= 1'b1;
    end else begin
      gain_low_front   <= ctrl1[C1_FRONT_LOW];
      gain_low_rear    <= ctrl1[C1_REAR_LOW];
      audio_mute       <= (next_state == st_muted);
      standby          <= !ctrl2[C2_STANDBY_OFF];
      timing_discharge <= ctrl2[C2_FAST_MUTE];
      clip_oe_n        <= !(ctrl1[C1_CLIP_TEN] ? c10_s : c1_s);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_reset_muted: assert property ($rose(reset_n) |-> audio_mute)
    else $error("not muted after reset");
  a_play_cmd: assert property ($fell(audio_mute) |-> $past(play_req) && !$past(force_mute))
    else $error("audio started without mute-off");
  a_gain_write: assert property ((wr_evt && wr.sub == SUB_CTRL1) |=> ##1 gain_low_front == $past(wr.data[C1_FRONT_LOW], 2))
    else $error("gain setting not applied");
  a_mute_wait: assert property ((state == st_muting && !force_mute && mute_cnt < CNT_W'(MUTE_CYCLES - 1)) |=> !audio_mute)
    else $error("muted before the charge delay");
  a_mute_done: assert property ((state == st_muting && !force_mute && mute_cnt == CNT_W'(MUTE_CYCLES - 1)) |=> audio_mute)
    else $error("mute late after the charge delay");
  a_supply_mute: assert property (supply_s |=> audio_mute)
    else $error("low supply did not mute");
  a_pin_mute: assert property (pin_s |=> audio_mute)
    else $error("timing pin low did not mute");
  a_fast_mute: assert property (ctrl2[C2_FAST_MUTE] |=> audio_mute && timing_discharge)
    else $error("fast mute not immediate");
  a_clip_flag: assert property (##1 clip_oe_n == !$past(ctrl1[C1_CLIP_TEN] ? c10_s : c1_s))
    else $error("clip flag wrong");
  a_clip_select: assert property ((ctrl1[C1_CLIP_TEN] && c10_s && !c1_s) |=> !clip_oe_n)
    else $error("clip threshold not selected");
  a_standby_play: assert property (!ctrl2[C2_STANDBY_OFF] |-> !play_req)
    else $error("play bit kept in standby");

  c_play: cover property ($fell(audio_mute));
  c_delayed_mute: cover property (state == st_muting ##1 state == st_muted);
  c_fast_mute: cover property (state == st_play ##1 ctrl2[C2_FAST_MUTE]);
endmodule : amp_i2c_mute_gain_control

// ---- bench/host_master.sv ----
// Purpose: host side of the serial control link, open drain master
// Assumes: pull-up on sda; scl stands high between frames
// Notes:   timing from a free 12 ns tick, each half bit lasts 2*PH ticks
`timescale 1ns/1ps
module host_master #(
  parameter int PH = 5
)(
  // wire level seen on sda
  input  wire logic sda,
  // pins driven by the host
  output logic      scl,
  output logic      sda_low
);
  logic tick;

  // ----------------------------------------
  // link timing and transfers
  // ----------------------------------------
  // free tick, unrelated in phase to clk_sys
  initial begin
    tick    = 1'b0;
    scl     = 1'b1;
    sda_low = 1'b0;
    forever #6.0 tick = ~tick;
  end

  task automatic wait_ph(input int n);
    repeat (n * PH) @(posedge tick);
    #1;
  endtask : wait_ph

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      wait_ph(1);
      sda_low = ~b[i];
      wait_ph(1);
      scl = 1'b1;
      wait_ph(2);
      scl = 1'b0;
    end
    wait_ph(1);
    sda_low = 1'b0;  // release for ack
    wait_ph(1);
    scl = 1'b1;
    wait_ph(2);
    ack = ~sda;
    scl = 1'b0;
  endtask : send_byte

  task automatic frame(input logic [7:0] q[$], output logic [7:0] acks);
    logic a;
    acks    = 8'h00;
    sda_low = 1'b1;
    wait_ph(2);
    scl = 1'b0;
    foreach (q[i]) begin
      send_byte(q[i], a);
      acks[i] = a;
    end
    wait_ph(1);
    sda_low = 1'b1;
    wait_ph(1);
    scl = 1'b1;
    wait_ph(2);
    sda_low = 1'b0;
    wait_ph(2);
  endtask : frame
endmodule : host_master

// ---- bench/tb.sv ----
// Purpose: self-checking bench of the amplifier control block
// Assumes: host model drives the link, pull-up on sda
// Notes:   mute delay shortened to MC cycles
`timescale 1ns/1ps
module tb;
  import amp_ctrl_pkg::*;
  localparam int MC = 50;
  logic       clk_sys, reset_n, scl, sda_low, sda, supply_low, timing_pin_low, clip_1pct, clip_10pct;
  logic       sda_o, sda_oe_n, gain_low_front, gain_low_rear, audio_mute, standby, timing_discharge;
  logic       clip_o, clip_oe_n;
  logic [7:0] c1, c2, acks, outs, r;
  logic [7:0] wa;
  int         n_fail, num_checks;

  // ----------------------------------------
  // design, host model, wire
  // ----------------------------------------
  // open drain wire with pull-up
  assign sda  = sda_low ? 1'b0 : (!sda_oe_n ? sda_o : 1'b1);
  assign outs = {3'b000, gain_low_front, gain_low_rear, audio_mute, standby, timing_discharge};
  assign wa   = {SLAVE_ADDR, 1'b0};

  amp_i2c_mute_gain_control #(.MUTE_CYCLES(MC)) amp_i2c_mute_gain_control_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .supply_low(supply_low), .timing_pin_low(timing_pin_low), .clip_1pct(clip_1pct),
    .clip_10pct(clip_10pct), .gain_low_front(gain_low_front), .gain_low_rear(gain_low_rear),
    .audio_mute(audio_mute), .standby(standby), .timing_discharge(timing_discharge),
    .clip_o(clip_o), .clip_oe_n(clip_oe_n));

  host_master host_master_inst (.sda(sda), .scl(scl), .sda_low(sda_low));

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  // settled controls from the two bytes and the force levels
  function automatic logic [7:0] exp_ctrl(input logic [7:0] a, input logic [7:0] b, input logic sl,
                                          input logic tp);
    logic hold;
    hold = sl | tp | ~b[C2_STANDBY_OFF] | b[C2_FAST_MUTE] | ~(a[C1_REAR_PLAY] | a[C1_FRONT_PLAY]);
    return {3'b000, a[C1_FRONT_LOW], a[C1_REAR_LOW], hold, ~b[C2_STANDBY_OFF], b[C2_FAST_MUTE]};
  endfunction : exp_ctrl

  // one write frame, mirror of the control bytes
  task automatic wr(input logic [7:0] adr, input logic [7:0] sub, input logic [7:0] d[$]);
    logic [7:0] q[$];
    logic [7:0] ea;
    q  = {adr, sub};
    ea = (adr == wa) ? 8'((1 << (d.size() + 2)) - 1) : 8'h00;
    foreach (d[i]) q.push_back(d[i]);
    host_master_inst.frame(q, acks);
    check(acks, ea, "ack pattern");
    foreach (d[i]) begin
      logic [6:0] s;
      s = sub[6:0] + (sub[SUB_AUTOINC_BIT] ? 7'(i) : 7'h00);
      if (adr == wa && s == SUB_CTRL1) c1 = d[i];
      if (adr == wa && s == SUB_CTRL2) c2 = d[i];
      c1[C1_FRONT_PLAY] = c1[C1_FRONT_PLAY] & c2[C2_STANDBY_OFF];
      c1[C1_REAR_PLAY]  = c1[C1_REAR_PLAY] & c2[C2_STANDBY_OFF];
    end
  endtask : wr

  task automatic settle_cmp();
    repeat (MC + 30) @(posedge clk_sys);
    #1;
    check(outs, exp_ctrl(c1, c2, supply_low, timing_pin_low), "controls");
    check({7'h00, clip_oe_n}, {7'h00, ~(c1[C1_CLIP_TEN] ? clip_10pct : clip_1pct)}, "clip flag");
  endtask : settle_cmp

  // ----------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // cut a hang short
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_fail++;
    stop_test();
  end

  initial begin
    {reset_n, supply_low, timing_pin_low, clip_1pct, clip_10pct} = 5'h00;
    {n_fail, num_checks} = {32'd0, 32'd0};
    {c1, c2} = {CTRL_RESET, CTRL_RESET};
    void'($urandom(32'h760a7bd6));
    repeat (10) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    check(outs, 8'h06, "reset controls");
    check({4'h0, clip_o, sda_o, clip_oe_n, sda_oe_n}, 8'h03, "reset pins");
    repeat (4) @(posedge clk_sys);
    #1;
    wr(wa ^ 8'h02, 8'h02, {8'h10});
    settle_cmp();
    host_master_inst.frame({wa | 8'h01}, acks);
    check(acks, 8'h01, "read address ack");
    wr(wa, 8'h02, {8'h10});
    wr(wa, 8'h01, {8'h06});
    settle_cmp();
    for (int n = 0; n < 6; n++) begin
      r = (8'($urandom) & 8'h19) | 8'h04;
      {clip_10pct, clip_1pct} = 2'($urandom);
      wr(wa, 8'h81, {r, 8'h10});
      settle_cmp();
    end
    wr(wa, 8'h02, {8'h00});
    settle_cmp();
    wr(wa, 8'h02, {8'h10});
    settle_cmp();
    wr(wa, 8'h01, {8'h16, 8'h0c});
    settle_cmp();
    for (int k = 0; k < 2; k++) begin
      {timing_pin_low, supply_low} = 2'(1 << k);
      repeat (6) @(posedge clk_sys);
      #1;
      check({7'h00, audio_mute}, 8'h01, "forced mute");
      {timing_pin_low, supply_low} = 2'b00;
      settle_cmp();
    end
    wr(wa, 8'h02, {8'h50});
    check(outs, exp_ctrl(c1, c2, 1'b0, 1'b0), "fast mute");
    wr(wa, 8'h02, {8'h10});
    settle_cmp();
    wr(wa, 8'h01, {8'h00});
    repeat (10) @(posedge clk_sys);
    #1;
    check({7'h00, audio_mute}, 8'h00, "mute still pending");
    repeat (30) @(posedge clk_sys);
    #1;
    check({7'h00, audio_mute}, 8'h01, "mute after delay");
    wr(wa, 8'h01, {8'h06});
    settle_cmp();
    reset_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    {c1, c2} = {CTRL_RESET, CTRL_RESET};
    repeat (2) @(posedge clk_sys);
    #1;
    check(outs, 8'h06, "second reset");
    stop_test();
  end
endmodule : tb
